// >>> hw/smst_wait_timing.v
// What this block does
// - normal memory: read strobe stretched by access-wait cycles
// - burst ROM: access-wait applies only to the first beat's strobe, read or write
// - access-wait codes 0-10 linear, then 12,15,20,25,31; zero ignores wait pin
// - burst ROM: burst-pitch wait cycles inserted in each later beat
// - normal memory: burst-pitch wait stretches the write strobe
// - burst-pitch uses the same code mapping and wait-pin enable, reset 1111
// - idle recovery cycles on bank switch or read-to-write in same bank
// - memory-type bit 0 is normal memory, 1 is burst ROM
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "smst_map.vh"

module smst_wait_timing (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // access requests from the bank controller
    input wire acc_start,
    input wire acc_write,
    input wire [1:0] acc_bank,
    input wire [5:0] acc_beats,
    output reg acc_busy,
    output reg acc_beat_done,
    // memory side
    input wire wait_n,
    output reg rd_strobe_n,
    output reg we_strobe_n
);

localparam ST_IDLE = 2'h0;
localparam ST_RCV = 2'h1;
localparam ST_STRB = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] ctrl_q;
reg [1:0] state_q;
reg [4:0] cnt_q;
reg [5:0] beats_q;
reg first_q;
reg wr_q;
reg [1:0] last_bank_q;
reg last_wr_q;
reg used_q;
reg wait_s1_q;
reg wait_s2_q;

wire [3:0] aw_code = ctrl_q[`SMST_AW_HI:`SMST_AW_LO];
wire [3:0] bp_code = ctrl_q[`SMST_BP_HI:`SMST_BP_LO];
wire [3:0] rcv_cycles = ctrl_q[`SMST_RCV_HI:`SMST_RCV_LO];
wire burst_rom = ctrl_q[`SMST_TYPE_BIT];

// shared decode keeps both fields on one mapping
function [4:0] code_to_cycles;
    input [3:0] code;
    begin
        case (code)
            4'hB: code_to_cycles = `SMST_CYC_B;
            4'hC: code_to_cycles = `SMST_CYC_C;
            4'hD: code_to_cycles = `SMST_CYC_D;
            4'hE: code_to_cycles = `SMST_CYC_E;
            4'hF: code_to_cycles = `SMST_CYC_F;
            default: code_to_cycles = {1'b0, code};
        endcase
    end
endfunction

// pick the field for the next strobe: first burst ROM beat (read or write) or normal read uses access-wait
function [3:0] pick_code;
    input is_wr;
    input is_first;
    begin
        if (burst_rom)
            pick_code = is_first ? aw_code : bp_code;
        else
            pick_code = is_wr ? bp_code : aw_code;
    end
endfunction

wire [3:0] cur_code = pick_code(wr_q, first_q);
// nonzero code monitors the pin, zero ignores it
wire wait_hold = (cur_code != 4'h0) && !wait_s2_q;
wire need_rcv = used_q && ((acc_bank != last_bank_q) || (!last_wr_q && acc_write));

////////////////////////////////////////////////////////////////////////////////
// register port

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        ctrl_q <= `SMST_CTRL_RST;
        reg_rdata <= 32'h00000000;
    end
    else
    begin
        if (reg_wr && reg_addr == `SMST_CTRL_OFS)
            ctrl_q <= reg_wdata & `SMST_CTRL_MASK;
        reg_rdata <= 32'h00000000;
        if (reg_rd && reg_addr == `SMST_CTRL_OFS)
            reg_rdata <= ctrl_q;
        else if (reg_rd && reg_addr == `SMST_STAT_OFS)
            reg_rdata <= {24'h000000, beats_q, state_q};
    end
end

////////////////////////////////////////////////////////////////////////////////
// wait pin synchroniser: the pin is asynchronous to clk

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        wait_s1_q <= 1'b1;
        wait_s2_q <= 1'b1;
    end
    else
    begin
        wait_s1_q <= wait_n;
        wait_s2_q <= wait_s1_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// access sequencer

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state_q <= ST_IDLE;
        cnt_q <= 5'h00;
        beats_q <= 6'h00;
        first_q <= 1'b0;
        wr_q <= 1'b0;
        last_bank_q <= 2'h0;
        last_wr_q <= 1'b0;
        used_q <= 1'b0;
        acc_busy <= 1'b0;
        acc_beat_done <= 1'b0;
        rd_strobe_n <= 1'b1;
        we_strobe_n <= 1'b1;
    end
    else
    begin
        acc_beat_done <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (acc_start)
                begin
                    acc_busy <= 1'b1;
                    wr_q <= acc_write;
                    first_q <= 1'b1;
                    // burst ROM reads run several beats; everything else is one
                    beats_q <= (burst_rom && !acc_write && acc_beats != 6'h00) ?
                        acc_beats : 6'h01;
                    last_bank_q <= acc_bank;
                    last_wr_q <= acc_write;
                    used_q <= 1'b1;
                    if (need_rcv && rcv_cycles != 4'h0)
                    begin
                        cnt_q <= {1'b0, rcv_cycles};
                        state_q <= ST_RCV;
                    end
                    else
                    begin
                        cnt_q <= code_to_cycles(pick_code(acc_write, 1'b1));
                        rd_strobe_n <= acc_write;
                        we_strobe_n <= !acc_write;
                        state_q <= ST_STRB;
                    end
                end
            end
            ST_RCV:
            begin
                if (cnt_q == 5'h01)
                begin
                    cnt_q <= code_to_cycles(cur_code);
                    rd_strobe_n <= wr_q;
                    we_strobe_n <= !wr_q;
                    state_q <= ST_STRB;
                end
                else
                    cnt_q <= cnt_q - 5'h01;
            end
            ST_STRB:
            begin
                // the strobe lasts one cycle plus the wait count, plus any pin hold
                if (cnt_q != 5'h00)
                    cnt_q <= cnt_q - 5'h01;
                else if (!wait_hold)
                begin
                    acc_beat_done <= 1'b1;
                    if (beats_q == 6'h01)
                    begin
                        rd_strobe_n <= 1'b1;
                        we_strobe_n <= 1'b1;
                        acc_busy <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        first_q <= 1'b0;
                        cnt_q <= code_to_cycles(bp_code);
                    end
                    beats_q <= beats_q - 6'h01;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule // smst_wait_timing

// >>> hw/smst_map.vh
`ifndef SMST_MAP_VH
`define SMST_MAP_VH
// register offset (byte address on the plain register port)
`define SMST_CTRL_OFS 8'h00
`define SMST_STAT_OFS 8'h04
// field positions in static_bank_control
`define SMST_RCV_HI 27
`define SMST_RCV_LO 24
`define SMST_AW_HI 23
`define SMST_AW_LO 20
`define SMST_BP_HI 19
`define SMST_BP_LO 16
`define SMST_TYPE_BIT 0
// writable bits and reset value
`define SMST_CTRL_MASK 32'h0FFF0001
`define SMST_CTRL_RST 32'h0FFF0000
// wait cycles for the five non-linear codes; lower codes count as themselves
`define SMST_CYC_B 5'h0C
`define SMST_CYC_C 5'h0F
`define SMST_CYC_D 5'h14
`define SMST_CYC_E 5'h19
`define SMST_CYC_F 5'h1F
`endif

// >>> tb/smst_chk.sv
`timescale 1ns/100ps
module smst_chk (
    input wire clk, arst_n, reg_wr, reg_rd, acc_start, acc_write, wait_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata, reg_rdata,
    input wire [1:0] acc_bank,
    input wire [5:0] acc_beats,
    input wire acc_busy, acc_beat_done, rd_strobe_n, we_strobe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    two_strobe_a: assert property (rd_strobe_n || we_strobe_n) else $error("two strobes");
    rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
    start_busy_a: assert property (acc_start && !acc_busy |=> acc_busy) else $error("busy");
    rd_soon_a: assert property (acc_start && !acc_busy && !acc_write |=> ##[0:15] !rd_strobe_n)
        else $error("rd late");
    wr_soon_a: assert property (acc_start && !acc_busy && acc_write |=> ##[0:15] !we_strobe_n)
        else $error("wr late");
    rd_busy_a: assert property (!rd_strobe_n |-> acc_busy) else $error("rd idle");
    beat_strobe_a: assert property (acc_beat_done |-> !$past(rd_strobe_n) || !$past(we_strobe_n))
        else $error("beat without strobe");
    end_idle_a: assert property ($fell(acc_busy) |-> rd_strobe_n && we_strobe_n)
        else $error("end");
    cover property ($fell(we_strobe_n));
    cover property (acc_beat_done && !rd_strobe_n);
    cover property (!wait_n && !rd_strobe_n);
endmodule // smst_chk
bind smst_wait_timing smst_chk chk_i (.clk, .arst_n, .reg_wr, .reg_rd, .acc_start, .acc_write,
    .wait_n, .reg_addr, .reg_wdata, .reg_rdata, .acc_bank, .acc_beats, .acc_busy,
    .acc_beat_done, .rd_strobe_n, .we_strobe_n);

// >>> tb/smst_mem.sv
`timescale 1ns/100ps
// wait pin is driven low for hold cycles from one cycle after a strobe starts, and driven high otherwise
module smst_mem (
    input wire clk,
    input wire rd_strobe_n,
    input wire we_strobe_n,
    input wire [7:0] hold,
    output wire wait_n
);
    logic [7:0] cnt_q = 8'h00;
    logic idle_q = 1'b1;
    always @(posedge clk)
    begin
        idle_q <= rd_strobe_n & we_strobe_n;
        if (idle_q && !(rd_strobe_n & we_strobe_n))
            cnt_q <= hold;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    assign wait_n = (cnt_q == 8'h00);
endmodule // smst_mem

// >>> tb/tb_smst_wait_timing.sv
`timescale 1ns/100ps
`include "smst_map.vh"
module tb_smst_wait_timing;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, acc_start = 0, acc_write = 0;
    logic [7:0] reg_addr = 8'h00, hold = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [1:0] acc_bank = 2'h0;
    logic [5:0] acc_beats = 6'h01;
    wire [31:0] reg_rdata;
    wire acc_busy, acc_beat_done, wait_n, rd_strobe_n, we_strobe_n;
    int fail_count = 0, checks_done = 0, lead, len, bd, c;
    always #4 clk = ~clk;
    smst_wait_timing dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .acc_start, .acc_write, .acc_bank, .acc_beats, .acc_busy, .acc_beat_done, .wait_n,
        .rd_strobe_n, .we_strobe_n);
    smst_mem mem (.clk, .rd_strobe_n, .we_strobe_n, .hold, .wait_n);
    function automatic int mp(input int k);
        return k <= 10 ? k : k == 11 ? 12 : k == 12 ? 15 : k == 13 ? 20 : k == 14 ? 25 : 31;
    endfunction
    function automatic logic [31:0] cw(input int r, aw, bp, t);
        return {4'h0, r[3:0], aw[3:0], bp[3:0], 15'h0, t[0]};
    endfunction
    task automatic chk(input bit ok);
        checks_done++;
        if (!ok)
        begin
            fail_count++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task automatic wr(input logic [31:0] d);
        @(posedge clk);
        reg_addr <= `SMST_CTRL_OFS;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata === e);
    endtask
    // measures idle lead, strobe length and beat count of one access
    task automatic acc(input logic w, input logic [5:0] n, input logic [1:0] b);
        @(posedge clk);
        acc_write <= w;
        acc_bank <= b;
        acc_beats <= n;
        acc_start <= 1'b1;
        @(posedge clk);
        acc_start <= 1'b0;
        lead = 0;
        len = 0;
        bd = 0;
        for (int i = 0; i < 400; i++)
        begin
            #1;
            // only the strobe that matches the direction counts
            if ((w ? we_strobe_n : rd_strobe_n) === 1'b0) len++;
            else if (len == 0) lead++;
            if (acc_beat_done === 1'b1) bd++;
            if (acc_busy !== 1'b1 && i > 0) break;
            @(posedge clk);
        end
    endtask
    task automatic end_sim;
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(`SMST_CTRL_OFS, 32'h0FFF0000);
        rd(8'h40, 32'h0);
        wr(32'hFFFFFFFF);
        rd(`SMST_CTRL_OFS, 32'h0FFF0001);
        for (c = 0; c < 16; c++)
        begin
            wr(cw(0, c, 15 - c, 0));
            acc(0, 1, 0);
            chk(len == mp(c) + 1 && bd == 1);
            acc(1, 1, 0);
            chk(len == mp(15 - c) + 1 && bd == 1);
        end
        wr(cw(0, 2, 5, 1));
        acc(0, 3, 0);
        chk(len == 15 && bd == 3);
        wr(cw(4, 1, 1, 0));
        fork
            acc(0, 1, 1);
            begin
                // status read lands one cycle into recovery: one beat left, state 1
                @(posedge clk);
                rd(`SMST_STAT_OFS, 32'h00000005);
            end
        join
        chk(lead == 4);
        acc(0, 1, 1);
        chk(lead == 0);
        acc(1, 1, 1);
        chk(lead == 4);
        wr(cw(0, 5, 1, 0));
        hold <= 8'h14;
        acc(0, 1, 1);
        chk(len >= 20 && len <= 26);
        wr(cw(0, 0, 0, 0));
        acc(0, 1, 1);
        chk(len == 1);
        // reset in mid-run: fields return to 1111 and the first access never recovers
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(`SMST_CTRL_OFS, 32'h0FFF0000);
        acc(1, 1, 2);
        chk(lead == 0 && len == 32);
        end_sim;
    end
    initial
    begin
        #100000;
        fail_count++;
        end_sim;
    end
endmodule // tb_smst_wait_timing
